/* dv/tb_top.sv */
// self-checking bench for the timer0 block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic mclk, rst_n, reg_wr, option_wr, direction_wr, clear_watchdog_instr, watchdog_tick, run, use_cmp;
	logic ext_count_pin, comparator_result, watchdog_out, count_pin_dir;
	logic [7:0] reg_addr, reg_wdata, timer_count, comparator_control, t0;
	logic [1:0] phase;
	logic [7:0] ext_opt [4] = '{8'h28, 8'h38, 8'h20, 8'h28};
	logic [7:0] ext_exp [4] = '{8'h0a, 8'h0a, 8'h05, 8'h0a};
	int mismatches = 0;
	int check_count = 0;
	tmz_timer0 dut_u (.mclk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .option_wr, .direction_wr,
		.clear_watchdog_instr, .timer_count, .comparator_control, .ext_count_pin, .comparator_result,
		.watchdog_tick, .watchdog_out, .count_pin_dir, .phase);
	tmz_src_model src_u (.mclk, .run, .use_cmp, .ext_count_pin, .comparator_result);
	//////////
	task automatic cy(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : cy
	// kind 0 register, 1 option, 2 direction, 3 clear watchdog
	task automatic put(input int k, input logic [7:0] d, input logic [7:0] a = tmz_pkg::TIMER_COUNT_ADDR);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= k == 0;
		option_wr <= k == 1;
		direction_wr <= k == 2;
		clear_watchdog_instr <= k == 3;
		@(posedge mclk);
		{reg_wr, option_wr, direction_wr, clear_watchdog_instr} <= 4'h0;
	endtask : put
	task automatic tick();
		@(posedge mclk);
		watchdog_tick <= 1'b1;
		cy(6);
		@(posedge mclk);
		watchdog_tick <= 1'b0;
		cy(6);
	endtask : tick
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : close_out
	//////////
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		#200000;
		mismatches++;
		close_out();
	end
	initial begin
		{rst_n, reg_wr, option_wr, direction_wr, clear_watchdog_instr, watchdog_tick, run, use_cmp} = 8'h00;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		cy(1);
		chk("timer", timer_count, tmz_pkg::TIMER_RESET);
		chk("cmp", {1'b0, comparator_control[6:0]}, 8'h7f);
		chk("dir", count_pin_dir, 8'h01);
		put(1, 8'h08);
		put(0, 8'hf0);
		cy(12);
		chk("inhibit", timer_count, 8'hf1);
		cy(64);
		chk("wrap", timer_count, 8'h01);
		put(2, 8'h00);
		cy(3);
		chk("dir", count_pin_dir, 8'h00);
		for (int n = 0; n < 8; n++) begin
			put(1, 8'(n));
			cy(40);
			t0 = timer_count;
			cy(8 << (n + 1));
			chk("rate", timer_count - t0, 8'h02);
		end
		t0 = timer_count;
		for (int k = 0; k < 1100 && timer_count === t0; k++) cy(1);
		cy(800);
		// cleared ratio-256 tap first rises 128 cycles after the write
		put(0, 8'h20);
		cy(400);
		chk("clear", timer_count, 8'h20);
		cy(200);
		chk("clear", timer_count, 8'h21);
		tick();
		put(3, 8'h00);
		put(0, 8'h00);
		put(1, 8'h08);
		put(3, 8'h00);
		tick();
		chk("wdt", watchdog_out, 8'h01);
		put(0, 8'h55);
		cy(3);
		chk("wdt", watchdog_out, 8'h01);
		put(3, 8'h00);
		cy(3);
		chk("wdt", watchdog_out, 8'h00);
		for (int i = 0; i < 4; i++) begin
			put(1, ext_opt[i]);
			put(0, i == 3 ? 8'hef : 8'hff, tmz_pkg::COMPARATOR_CONTROL_ADDR);
			cy(16);
			put(0, 8'h00);
			cy(12);
			chk("dir", count_pin_dir, 8'h01);
			@(posedge mclk);
			use_cmp <= i == 3;
			run <= 1'b1;
			repeat (80) @(posedge mclk);
			run <= 1'b0;
			cy(24);
			chk("ext", timer_count, ext_exp[i]);
		end
		chk("cmp", comparator_control, 8'h6f);
		close_out();
	end
endmodule : tb_top
`default_nettype wire

/* dv/tmz_src_model.sv */
// external count source: pin or comparator output
`timescale 1ns/1ps
`default_nettype none
module tmz_src_model (
	// control
	input wire logic mclk,
	input wire logic run,
	input wire logic use_cmp,
	// source lines
	output logic ext_count_pin,
	output logic comparator_result
);
	logic [1:0] cnt_q = 2'h0;
	logic wave_q = 1'b0;
	// four clocks each phase, well over two oscillator periods
	always_ff @(posedge mclk) begin
		cnt_q <= run ? cnt_q + 2'h1 : 2'h0;
		if (run && cnt_q == 2'h3) wave_q <= ~wave_q;
	end
	assign ext_count_pin = wave_q & ~use_cmp;
	assign comparator_result = wave_q & use_cmp;
endmodule : tmz_src_model
`default_nettype wire

/* dv/tmz_timer0_monitor.sv */
// concurrent checks on the timer0 block ports
`timescale 1ns/1ps
`default_nettype none
module tmz_timer0_monitor (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// register side and watchdog tick
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic option_wr,
	input wire logic watchdog_tick,
	// observed outputs
	input wire logic [7:0] timer_count,
	input wire logic watchdog_out,
	input wire logic count_pin_dir,
	input wire logic [1:0] phase
);
	logic tw;
	logic [7:0] opt_q;
	logic [1:0] inh_q;
	assign tw = reg_wr && reg_addr == tmz_pkg::TIMER_COUNT_ADDR;
	// shadow copies, since option and inhibit are not visible at the ports
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) opt_q <= tmz_pkg::OPTION_RESET;
		else if (option_wr) opt_q <= reg_wdata;
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) inh_q <= 2'h0;
		else if (tw) inh_q <= tmz_pkg::WRITE_INHIBIT_CYCLES;
		else if (phase == 2'h3 && inh_q != 2'h0) inh_q <= inh_q - 2'h1;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	//////////
	a_phase_walk: assert property (phase == 2'h3 |=> phase == 2'h0 ##1 phase == 2'h1)
		else $error("phase order");
	a_write_load: assert property (tw |=> timer_count == $past(reg_wdata))
		else $error("write lost");
	a_write_inhibit: assert property (inh_q != 2'h0 && !tw |=> $stable(timer_count))
		else $error("count in inhibit");
	a_off_phase: assert property (phase != 2'h3 && !tw |=> $stable(timer_count))
		else $error("count off cycle end");
	a_cycle_count: assert property (phase == 2'h3 && !tw && inh_q == 2'h0 && !opt_q[5] && opt_q[3]
		|=> timer_count == $past(timer_count) + 8'h01) else $error("cycle missed");
	a_one_step: assert property (!tw |=> timer_count - $past(timer_count) <= 8'h01)
		else $error("timer jumped");
	a_dir_forced: assert property (opt_q[5] && !option_wr |=> count_pin_dir)
		else $error("dir not forced");
	a_wdt_pulse: assert property (!opt_q[3] && $rose(watchdog_tick) |-> ##[1:4] watchdog_out)
		else $error("tick lost");
	c_ext: cover property (opt_q[5] && $changed(timer_count));
	c_wdt: cover property (opt_q[3] && $rose(watchdog_out));
	c_inh: cover property (inh_q == 2'h2 && phase == 2'h3);
endmodule : tmz_timer0_monitor
bind tmz_timer0 tmz_timer0_monitor chk_u (.mclk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .option_wr,
	.watchdog_tick, .timer_count, .watchdog_out, .count_pin_dir, .phase);
`default_nettype wire

/* rtl/tmz_pkg.sv */
// constants and types for the timer0 counter with shared prescaler
// Contract
// [R01] sample scaler output on phase two and four
// [R02] unscaled source high and low two periods
// [R03] scaled source period four periods over ratio
// [R04] ripple prescaler divides external input first
// [R05] scaled source phases meet minimum pulse width
// [R06] timer increments only after synchronisation
// [R07] one 8-bit scaler, timer or watchdog only
// [R08] assignment and ratio from option low nibble
// [R09] timer write clears scaler when timer-assigned
// [R10] clear-watchdog clears scaler when watchdog-assigned
// [R11] scaler count not software visible
// [R12] scaler resets to all zeros
// [R13] assignment changeable on the fly
// [R14] software order: clear watchdog, timer, then option
// [R15] software clears watchdog before giving scaler timer
// [R16] source select overrides count pin direction
// [R17] timer write blocks increments two cycles
// [R18] source select: instruction cycles or external edges
// [R19] edge select: clear rising, set falling
// [R20] assign clear gives timer ratios 2 to 256
// [R21] ratio code n divides by two to n+1
package tmz_pkg;
	localparam logic [7:0] TIMER_COUNT_ADDR = 8'h01;
	localparam logic [7:0] COMPARATOR_CONTROL_ADDR = 8'h07;
	localparam logic [7:0] OPTION_RESET = 8'hff;
	localparam logic [7:0] COMPARATOR_RESET = 8'hff;
	localparam logic [3:0] PIN_DIRECTION_RESET = 4'hf;
	localparam logic [7:0] SCALER_RESET = 8'h00;
	localparam logic [7:0] TIMER_RESET = 8'h00;
	localparam int OPT_SOURCE_BIT = 5;
	localparam int OPT_EDGE_BIT = 4;
	localparam int OPT_ASSIGN_BIT = 3;
	localparam int OPT_RATIO_LSB = 0;
	localparam int CMP_RESULT_BIT = 7;
	localparam int CMP_DRIVE_N_BIT = 6;
	localparam int CMP_COUNT_SEL_BIT = 4;
	localparam int COUNT_PIN_BIT = 2;
	localparam int PHASES_PER_CYCLE = 4;
	localparam logic [1:0] PHASE_TWO = 2'h1;
	localparam logic [1:0] PHASE_FOUR = 2'h3;
	localparam logic [1:0] WRITE_INHIBIT_CYCLES = 2'h2;
	typedef enum logic [1:0] {TMZ_SRC_CYCLE, TMZ_SRC_COMPARATOR, TMZ_SRC_PIN} tmz_src_e;
endpackage : tmz_pkg

/* rtl/tmz_scaler.sv */
// shared 8-bit prescaler counter with ratio tap
`timescale 1ns/1ps
`default_nettype none
module tmz_scaler #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// control
	input wire logic clear,
	input wire logic step,
	input wire logic [2:0] ratio,
	// tap
	output logic tap
);
	logic [WIDTH-1:0] cnt_q;

	// counter never reaches the register bus
	always_ff @(posedge mclk or negedge rst_n) begin // [R11]
		if (!rst_n) begin
			cnt_q <= tmz_pkg::SCALER_RESET; // [R12]
		end else if (clear) begin
			cnt_q <= tmz_pkg::SCALER_RESET;
		end else if (step) begin
			cnt_q <= cnt_q + 1'b1; // [R04]
		end
	end

	// bit n toggles every 2^n steps, symmetric square output
	assign tap = cnt_q[ratio]; // [R21]
endmodule : tmz_scaler
`default_nettype wire

/* rtl/tmz_timer0.sv */
// timer0 counter with external sync, shared prescaler and option control
`timescale 1ns/1ps
`default_nettype none
module tmz_timer0 (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// core register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic option_wr,
	input wire logic direction_wr,
	input wire logic clear_watchdog_instr,
	output logic [7:0] timer_count,
	output logic [7:0] comparator_control,
	// pins and neighbours
	input wire logic ext_count_pin,
	input wire logic comparator_result,
	input wire logic watchdog_tick,
	output logic watchdog_out,
	output logic count_pin_dir,
	output logic [1:0] phase
);
	logic [1:0] phase_q;
	logic [7:0] option_q;
	logic [7:0] cmp_q;
	logic [3:0] dir_q;
	logic [7:0] timer_q;
	logic [1:0] inhibit_q;
	logic src_q;
	logic src_prev_q;
	logic ext_s1_q;
	logic ext_s2_q;
	logic ext_s2_prev_q;
	logic wdt_prev_q;
	logic wdt_out_q;
	logic pin_dir_q;
	logic [7:0] cmp_rd_q;
	logic timer_wr;
	logic to_timer;
	logic ext_mode;
	logic raw_src;
	logic edge_src;
	logic scl_step;
	logic scl_clear;
	logic scl_tap;
	logic count_now;
	logic cycle_end;
	tmz_pkg::tmz_src_e src_sel;

	////////////////////////////////////////////////////////////////////////
	// decoding

	assign timer_wr = reg_wr && (reg_addr == tmz_pkg::TIMER_COUNT_ADDR);
	assign to_timer = !option_q[tmz_pkg::OPT_ASSIGN_BIT]; // [R08] [R20]
	assign ext_mode = option_q[tmz_pkg::OPT_SOURCE_BIT]; // [R18]
	assign cycle_end = (phase_q == tmz_pkg::PHASE_FOUR);

	// source mux per the clock source table
	always_comb begin
		if (!ext_mode) begin
			src_sel = tmz_pkg::TMZ_SRC_CYCLE;
		end else if (cmp_q[tmz_pkg::CMP_COUNT_SEL_BIT] && cmp_q[tmz_pkg::CMP_DRIVE_N_BIT]) begin
			src_sel = tmz_pkg::TMZ_SRC_PIN;
		end else begin
			src_sel = tmz_pkg::TMZ_SRC_COMPARATOR;
		end
	end

	always_comb begin
		case (src_sel)
			tmz_pkg::TMZ_SRC_PIN: raw_src = ext_count_pin;
			tmz_pkg::TMZ_SRC_COMPARATOR: raw_src = comparator_result;
			default: raw_src = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// phase clock: each instruction cycle is four mclk

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			phase_q <= 2'h0;
		end else begin
			phase_q <= phase_q + 2'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// configuration registers, changeable any time

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			option_q <= tmz_pkg::OPTION_RESET;
		end else if (option_wr) begin
			option_q <= reg_wdata; // [R13]
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cmp_q <= tmz_pkg::COMPARATOR_RESET;
		end else if (reg_wr && reg_addr == tmz_pkg::COMPARATOR_CONTROL_ADDR) begin
			cmp_q <= reg_wdata;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			dir_q <= tmz_pkg::PIN_DIRECTION_RESET;
		end else if (direction_wr) begin
			dir_q <= reg_wdata[3:0];
		end
	end

	// external source forces the count pin to input
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pin_dir_q <= 1'b1;
		end else begin
			pin_dir_q <= ext_mode | dir_q[tmz_pkg::COUNT_PIN_BIT]; // [R16]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// edge select and prescaler stepping

	// falling edges become rising by inversion
	assign edge_src = raw_src ^ option_q[tmz_pkg::OPT_EDGE_BIT]; // [R19]

	// reset to the idle level after inversion, so no false scaler step follows reset
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			src_q <= tmz_pkg::OPTION_RESET[tmz_pkg::OPT_EDGE_BIT];
			src_prev_q <= tmz_pkg::OPTION_RESET[tmz_pkg::OPT_EDGE_BIT];
			wdt_prev_q <= 1'b0;
		end else begin
			src_q <= edge_src;
			src_prev_q <= src_q;
			wdt_prev_q <= watchdog_tick;
		end
	end

	// scaler clocked by whichever side owns it
	always_comb begin
		if (to_timer) begin // [R07]
			scl_step = ext_mode ? (src_q && !src_prev_q) : cycle_end;
		end else begin
			scl_step = watchdog_tick && !wdt_prev_q;
		end
	end

	assign scl_clear = to_timer ? timer_wr : clear_watchdog_instr; // [R09] [R10]

	tmz_scaler #(
		.WIDTH(8)
	) u_scaler (
		.mclk(mclk),
		.rst_n(rst_n),
		.clear(scl_clear),
		.step(scl_step),
		.ratio(option_q[tmz_pkg::OPT_RATIO_LSB +: 3]),
		.tap(scl_tap)
	);

	// watchdog sees the scaler tap only when it owns it
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wdt_out_q <= 1'b0;
		end else begin
			wdt_out_q <= to_timer ? (watchdog_tick && !wdt_prev_q) : scl_tap;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sync: sample only on phase two and phase four

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
		end else begin
			if (phase_q == tmz_pkg::PHASE_TWO) begin
				ext_s1_q <= to_timer ? scl_tap : src_q; // [R01]
			end
			if (cycle_end) begin
				ext_s2_q <= ext_s1_q; // [R01]
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ext_s2_prev_q <= 1'b0;
		end else if (cycle_end) begin
			ext_s2_prev_q <= ext_s2_q;
		end
	end

	// internal mode with scaler counts tap rising edges too; only the second stage is read
	always_comb begin
		if (ext_mode || to_timer) begin
			count_now = cycle_end && ext_s2_q && !ext_s2_prev_q; // [R06]
		end else begin
			count_now = cycle_end; // [R18]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// timer register

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			inhibit_q <= 2'h0;
		end else if (timer_wr) begin
			inhibit_q <= tmz_pkg::WRITE_INHIBIT_CYCLES; // [R17]
		end else if (cycle_end && inhibit_q != 2'h0) begin
			inhibit_q <= inhibit_q - 2'h1;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			timer_q <= tmz_pkg::TIMER_RESET;
		end else if (timer_wr) begin
			timer_q <= reg_wdata;
		end else if (count_now && inhibit_q == 2'h0) begin
			timer_q <= timer_q + 8'h01; // [R17]
		end
	end

	// comparator result bit is read-only, live
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cmp_rd_q <= tmz_pkg::COMPARATOR_RESET;
		end else begin
			cmp_rd_q <= {comparator_result, cmp_q[6:0]};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign timer_count = timer_q;
	assign comparator_control = cmp_rd_q;
	assign watchdog_out = wdt_out_q;
	assign count_pin_dir = pin_dir_q;
	assign phase = phase_q;
endmodule : tmz_timer0
`default_nettype wire
